// ### odsc_consts.vh
// Purpose: constants for the octal driver serial control and diagnostic block
// Assumes: 50 MHz system clock, link clock sampled as an ordinary input
// Notes: times are given in their own unit, cycle counts derived from them
// Contract
// - eight outputs, each latch, overload, status
// - internal reset is external OR undervoltage
// - outputs gated by one common reset line
// - shift serial input on falling clock edge
// - rising select copies shift register to latches
// - copy only on nonzero multiple of eight
// - falling select loads status into shift register
// - present shift bits on SO each rise
// - status high when output above threshold
// - status meaning depends on commanded state
// - mode low: overcurrent latches off after delay
// - delay timer restarts on valid transfer
// - overcurrent after expiry switches off within 15 us
// - mode high: overcurrent enters current regulation
// - mode high: overtemperature latches output off
// - latched-off shorted output reports high status
// - open load off output reports low status
// - control bit 0 on, 1 off
// - shutdown delay between 70 and 250 us
// - SO floats after select returns high
`ifndef ODSC_CONSTS_VH
`define ODSC_CONSTS_VH
`define ODSC_NUM_OUT 8
`define ODSC_CNT_W 4
`define ODSC_BYTE_MASK 4'h7
`define ODSC_CLK_MHZ 50
`define ODSC_DLY_US 150
`define ODSC_DLY_CYC (`ODSC_DLY_US * `ODSC_CLK_MHZ)
`define ODSC_TMR_W 16
`define ODSC_LATCH_RST 8'hFF
`define ODSC_FIFO_DEPTH 4
`define ODSC_FIFO_AW 2
`endif

// ### odsc_sync.v
// Purpose: two flip-flop synchroniser for one level
// Assumes: input from outside the clock domain
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module odsc_sync (
    // clock and reset
    input wire clock,
    input wire rst_n,
    // level in and out
    input wire din,
    output reg dout
);
    reg meta_q; // first stage
    // two stage capture
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule // odsc_sync
`default_nettype wire

// ### odsc_fifo.v
// Purpose: small fifo between frame capture and output latches
// Assumes: single clock
// Notes: width and depth parameters, depth a power of two
`timescale 1ns/100ps
`default_nettype none
module odsc_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // clock and reset
    input wire clock,
    input wire rst_n,
    // write side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // read side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage
    reg [AW-1:0] wr_q; // write pointer
    reg [AW-1:0] rd_q; // read pointer
    reg [AW:0] cnt_q; // fill level
    wire push;
    wire pop;
    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    // storage write, no reset needed
    always @(posedge clock) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end
    // pointers and level
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // odsc_fifo
`default_nettype wire

// ### odsc_top.v
// Purpose: serial control, overload latching and diagnostics of eight drivers
// Assumes: link pins sampled by the 50 MHz clock after two flip-flops
// Notes: analog comparators and fault sensing arrive as plain inputs
`include "odsc_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module odsc_top #(
    parameter NOUT = `ODSC_NUM_OUT,
    parameter DLY_CYC = `ODSC_DLY_CYC
) (
    // clock and resets
    input wire clock,
    input wire rst_n,
    input wire ext_reset_n,
    input wire uv_reset,
    // serial link pins
    input wire sclk,
    input wire select_n,
    input wire si,
    output reg so,
    output wire so_oe_n,
    // fault mode and analog sense
    input wire fault_mode_select,
    input wire [NOUT-1:0] above_diag_threshold,
    input wire [NOUT-1:0] over_current,
    input wire [NOUT-1:0] over_temp,
    // driver controls
    output wire [NOUT-1:0] out_on,
    output wire [NOUT-1:0] current_regulate,
    output wire [NOUT-1:0] overload_latched,
    output wire chip_reset
);
    // synchronised pins
    wire sclk_s;
    wire sel_n_s;
    wire si_s;
    wire ext_rst_n_s;
    wire uv_s;
    reg sclk_d_q; // previous clock sample
    reg sel_d_q; // previous select sample
    wire sclk_rise;
    wire sclk_fall;
    wire sel_fall;
    wire sel_rise;
    reg [NOUT-1:0] shift_q; // shift register
    reg [`ODSC_CNT_W-1:0] bits_q; // low bits of clock count
    reg any_q; // at least one clock seen
    reg [NOUT-1:0] latch_q; // control latches, 1 means off
    reg [NOUT-1:0] ovl_q; // overload latches
    reg [`ODSC_TMR_W-1:0] tmr_q; // shutdown delay timer
    reg tmr_run_q; // timer still counting
    wire frame_ok;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [NOUT-1:0] fifo_out_data;
    wire int_reset;
    wire [NOUT-1:0] on_cmd;
    genvar gi;

    // pin synchronisers
    odsc_sync u_sclk (.clock(clock), .rst_n(rst_n), .din(sclk), .dout(sclk_s));
    odsc_sync u_sel (.clock(clock), .rst_n(rst_n), .din(~select_n), .dout(sel_n_s));
    odsc_sync u_si (.clock(clock), .rst_n(rst_n), .din(si), .dout(si_s));
    odsc_sync u_ext (.clock(clock), .rst_n(rst_n), .din(ext_reset_n), .dout(ext_rst_n_s));
    odsc_sync u_uv (.clock(clock), .rst_n(rst_n), .din(uv_reset), .dout(uv_s));

    // internal reset from either source
    assign int_reset = ~ext_rst_n_s | uv_s;
    assign chip_reset = int_reset;

    // edge detection on synchronised pins, sel_n_s is active-high selected
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d_q <= 1'b0;
            sel_d_q <= 1'b0;
        end else begin
            sclk_d_q <= sclk_s;
            sel_d_q <= sel_n_s;
        end
    end
    assign sclk_rise = sclk_s & ~sclk_d_q;
    assign sclk_fall = ~sclk_s & sclk_d_q;
    assign sel_fall = sel_n_s & ~sel_d_q; // select goes low
    assign sel_rise = ~sel_n_s & sel_d_q; // select goes high

    // count filter: nonzero multiple of eight clocks
    assign frame_ok = any_q && ((bits_q & `ODSC_BYTE_MASK) == 4'h0);

    // shift register, status load and bit counter
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= {NOUT{1'b0}};
            bits_q <= {`ODSC_CNT_W{1'b0}};
            any_q <= 1'b0;
        end else if (sel_fall) begin
            shift_q <= above_diag_threshold;
            bits_q <= {`ODSC_CNT_W{1'b0}};
            any_q <= 1'b0;
        end else if (sel_n_s && sclk_fall) begin
            shift_q <= {shift_q[NOUT-2:0], si_s};
            bits_q <= bits_q + 1'b1;
            any_q <= 1'b1;
        end
    end

    // serial out: msb on select fall, next bit each rising clock
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            so <= 1'b0;
        end else if (sel_fall) begin
            so <= above_diag_threshold[NOUT-1];
        end else if (sel_n_s && sclk_rise) begin
            so <= shift_q[NOUT-2];
        end
    end
    // drive only while selected, float afterwards
    assign so_oe_n = ~sel_n_s;

    // valid frames queue toward the latches
    odsc_fifo #(
        .WIDTH(NOUT),
        .DEPTH(`ODSC_FIFO_DEPTH),
        .AW(`ODSC_FIFO_AW)
    ) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(sel_rise && frame_ok),
        .in_ready(fifo_in_ready),
        .in_data(shift_q),
        .out_valid(fifo_out_valid),
        .out_ready(1'b1),
        .out_data(fifo_out_data)
    );

    // output latches, overload latches and delay timer
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            latch_q <= `ODSC_LATCH_RST;
            ovl_q <= {NOUT{1'b0}};
            tmr_q <= {`ODSC_TMR_W{1'b0}};
            tmr_run_q <= 1'b0;
        end else if (int_reset) begin
            latch_q <= `ODSC_LATCH_RST;
            ovl_q <= {NOUT{1'b0}};
            tmr_q <= {`ODSC_TMR_W{1'b0}};
            tmr_run_q <= 1'b0;
        end else if (fifo_out_valid) begin
            latch_q <= fifo_out_data;
            ovl_q <= {NOUT{1'b0}}; // new write re-arms outputs
            tmr_q <= DLY_CYC[`ODSC_TMR_W-1:0];
            tmr_run_q <= 1'b1;
        end else begin
            if (tmr_run_q) begin
                if (tmr_q == {{(`ODSC_TMR_W-1){1'b0}}, 1'b1}) begin
                    tmr_run_q <= 1'b0;
                end
                tmr_q <= tmr_q - 1'b1;
            end
            // low mode latches overcurrent once delay is over, immediately after
            if (!fault_mode_select && !tmr_run_q) begin
                ovl_q <= ovl_q | (over_current & on_cmd);
            end
            if (fault_mode_select) begin
                ovl_q <= ovl_q | (over_temp & on_cmd);
            end
        end
    end

    // per output drive decode
    generate
        for (gi = 0; gi < NOUT; gi = gi + 1) begin : g_out
            // bit 0 commands on
            assign on_cmd[gi] = ~latch_q[gi] & ~int_reset;
            assign out_on[gi] = on_cmd[gi] & ~ovl_q[gi];
            assign current_regulate[gi] = out_on[gi] & fault_mode_select
                & over_current[gi];
            assign overload_latched[gi] = ovl_q[gi];
        end
    endgenerate
endmodule // odsc_top
`default_nettype wire

// ### odsc_chk.sv
// Purpose: port checker for odsc_top
// Assumes: link pins pass two flops inside
// Notes: bound below the module
`timescale 1ns/100ps
`default_nettype none
module odsc_chk #(parameter NOUT = 8) (
    // clock and resets
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ext_reset_n,
    input wire logic uv_reset,
    // link pins
    input wire logic select_n,
    input wire logic so,
    input wire logic so_oe_n,
    // sense and drive
    input wire logic fault_mode_select,
    input wire logic [NOUT-1:0] above_diag_threshold,
    input wire logic [NOUT-1:0] over_current,
    input wire logic [NOUT-1:0] out_on,
    input wire logic [NOUT-1:0] current_regulate,
    input wire logic [NOUT-1:0] overload_latched,
    input wire logic chip_reset
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire src = !ext_reset_n || uv_reset; // either reset source active
    chk_reset_or_on: assert property (src [*4] |-> chip_reset)
        else $error("reset source not seen");
    chk_reset_or_off: assert property (!src [*4] |-> !chip_reset)
        else $error("reset held without source");
    chk_reset_gates: assert property (chip_reset |-> out_on == '0)
        else $error("output on during reset");
    chk_overload_off: assert property ((out_on & overload_latched) == '0)
        else $error("overloaded output still on");
    chk_regulate_mode: assert property (current_regulate ==
        (out_on & over_current & {NOUT{fault_mode_select}}))
        else $error("current regulation wrong");
    chk_so_float: assert property (select_n [*4] |-> so_oe_n)
        else $error("so driven while deselected");
    chk_so_drive: assert property (!select_n [*4] |-> !so_oe_n)
        else $error("so not driven while selected");
    chk_status_load: assert property ($fell(so_oe_n) |=>
        so == above_diag_threshold[NOUT-1])
        else $error("first status bit wrong");
    chk_latch_hold: assert property ((!select_n && !chip_reset && over_current == '0)
        [*8] |-> $stable(out_on))
        else $error("outputs moved inside a frame");
    cover property ($fell(so_oe_n));
    cover property ($rose(|overload_latched));
    cover property (|current_regulate);
endmodule // odsc_chk
bind odsc_top odsc_chk #(.NOUT(NOUT)) u_odsc_chk (.clock(clock), .rst_n(rst_n),
    .ext_reset_n(ext_reset_n), .uv_reset(uv_reset), .select_n(select_n), .so(so),
    .so_oe_n(so_oe_n), .fault_mode_select(fault_mode_select),
    .above_diag_threshold(above_diag_threshold), .over_current(over_current),
    .out_on(out_on), .current_regulate(current_regulate),
    .overload_latched(overload_latched), .chip_reset(chip_reset));
`default_nettype wire

// ### odsc_master.sv
// Purpose: serial master model facing odsc_top
// Assumes: 240 ns link clock period
// Notes: clock stands low outside frames
`timescale 1ns/100ps
`default_nettype none
module odsc_master (
    // alignment clock
    input wire logic clock,
    // link pins
    output logic sclk,
    output logic select_n,
    output logic si,
    input wire logic so
);
    logic [15:0] rx = '0; // bits read back
    initial begin
        sclk = 1'b0;
        select_n = 1'b1;
        si = 1'b0;
    end
    // n bits of d, msb first; select moves with sclk low
    task automatic frame(input int n, input logic [15:0] d);
        @(negedge clock);
        select_n = 1'b0;
        rx = '0;
        for (int i = n - 1; i >= 0; i--) begin
            #80 si = d[i];
            #80 rx = {rx[14:0], so};
            sclk = 1'b1;
            #80 sclk = 1'b0;
        end
        #160 select_n = 1'b1;
        si = ~si; // released line shows no stale value
        #320;
    endtask
endmodule // odsc_master
`default_nettype wire

// ### odsc_top_tb_top.sv
// Purpose: self-checking bench for odsc_top
// Assumes: odsc_master drives the link
// Notes: shutdown delay shortened to 40 cycles
`timescale 1ns/100ps
`default_nettype none
module odsc_top_tb_top;
    logic clock = 1'b0, rst_n = 1'b0, ext_reset_n = 1'b1, uv_reset = 1'b0;
    logic fault_mode_select = 1'b0, sclk, select_n, si, so, so_oe_n, chip_reset;
    logic [7:0] above_diag_threshold = 8'h3C, over_current = '0, over_temp = '0;
    logic [7:0] out_on, current_regulate, overload_latched;
    int fail_count = 0, total_checks = 0, cycles = 0;
    wire so_pin = so_oe_n ? ~so : so; // released pin shows no stale value
    odsc_top #(.DLY_CYC(40)) u_odsc_top (.clock(clock), .rst_n(rst_n),
        .ext_reset_n(ext_reset_n), .uv_reset(uv_reset), .sclk(sclk), .select_n(select_n),
        .si(si), .so(so), .so_oe_n(so_oe_n), .fault_mode_select(fault_mode_select),
        .above_diag_threshold(above_diag_threshold), .over_current(over_current),
        .over_temp(over_temp), .out_on(out_on), .current_regulate(current_regulate),
        .overload_latched(overload_latched), .chip_reset(chip_reset));
    odsc_master u_odsc_master (.clock(clock), .sclk(sclk), .select_n(select_n),
        .si(si), .so(so_pin));
    initial begin
        forever #10 clock = ~clock;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic t_write;
        u_odsc_master.frame(8, 16'h00A5);
        check(out_on, 8'h5A);
        check(u_odsc_master.rx[7:0], 8'h3C);
        u_odsc_master.frame(16, 16'h000F);
        check(out_on, 8'hF0);
        check(u_odsc_master.rx[15:8], 8'h3C);
        check(u_odsc_master.rx[7:0], 8'h00);
        $display("t_write done");
    endtask
    task automatic t_refuse;
        u_odsc_master.frame(5, 16'h0000);
        check(out_on, 8'hF0);
        u_odsc_master.frame(0, 16'h0000);
        check(out_on, 8'hF0);
        $display("t_refuse done");
    endtask
    task automatic t_short;
        u_odsc_master.frame(8, 16'h0000);
        over_current = 8'h01;
        wait_n(5);
        check(out_on, 8'hFF);
        wait_n(60);
        check(out_on, 8'hFE);
        check(overload_latched, 8'h01);
        over_current = 8'h03;
        wait_n(3);
        check(out_on, 8'hFC);
        above_diag_threshold = 8'h03;
        u_odsc_master.frame(8, 16'h0000);
        check(u_odsc_master.rx[7:0], 8'h03);
        check(out_on, 8'hFF);
        over_current = 8'h00;
        $display("t_short done");
    endtask
    task automatic t_mode_high;
        fault_mode_select = 1'b1;
        over_current = 8'h04;
        wait_n(60);
        check(current_regulate, 8'h04);
        over_temp = 8'h04;
        wait_n(4);
        check(overload_latched, 8'h04);
        check(out_on, 8'hFB);
        over_temp = 8'h00;
        over_current = 8'h00;
        fault_mode_select = 1'b0;
        $display("t_mode_high done");
    endtask
    task automatic t_reset;
        for (int k = 0; k < 2; k++) begin
            u_odsc_master.frame(8, 16'h0000);
            ext_reset_n = (k != 0);
            uv_reset = (k == 1);
            wait_n(5);
            check({7'h00, chip_reset}, 8'h01);
            check(out_on, 8'h00);
            ext_reset_n = 1'b1;
            uv_reset = 1'b0;
            wait_n(5);
            check(out_on, 8'h00);
        end
        $display("t_reset done");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        wait_n(10);
        rst_n = 1'b1;
        wait_n(4);
        t_write();
        t_refuse();
        t_short();
        t_mode_high();
        t_reset();
        conclude();
    end
endmodule // odsc_top_tb_top
`default_nettype wire
